// *** dv/ssr_load.sv ***
`timescale 1ns/10ps
`default_nettype none
// relay load on both outputs, counting the cycles each side is energised
module ssr_load (
	input wire logic mclk,
	input wire logic clr,
	input wire logic heat_out,
	input wire logic cool_out,
	output int heat_on,
	output int cool_on
);
	// a relay only follows its drive, so energy is the count of driven cycles
	always_ff @(posedge mclk) begin
		heat_on <= clr ? 0 : heat_on + int'(heat_out);
		cool_on <= clr ? 0 : cool_on + int'(cool_out);
	end
endmodule : ssr_load
`default_nettype wire

// *** dv/test_time_proportional_output.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin miscompares++; \
	$display("[ERR] %s expected %0h seen %0h", nm, e, s); end end
module test_time_proportional_output;
	localparam int TCK = 2;
	logic mclk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic heat_out, cool_out, restart_pulse, irq, ld_clr;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, q, q_old;
	logic [3:0] s_axi_wstrb, tune_event;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int heat_on, cool_on, miscompares, n_compared, cyc, nrst, mv, per, v;
	int codes[$] = '{-2, -1, 0, 1, 3}; // short and long periods as a controller picks
	time_proportional_output #(.TICK_CYCLES(TCK)) uut (.mclk, .sys_rst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tune_event, .heat_out, .cool_out,
		.restart_pulse, .irq);
	ssr_load load (.mclk, .clr(ld_clr), .heat_out, .cool_out, .heat_on, .cool_on);
	// period length in 0.1 s ticks for a period code
	function automatic int ticks(int c);
		return c == -2 ? 1 : c == -1 ? 2 : c == 0 ? 5 : c * 10;
	endfunction : ticks
	task automatic stop_test();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	// one register access; handshakes are read at the falling edge where they are settled
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		logic [2:0] hs;
		logic done;
		done = 1'b0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{we}};
		{s_axi_arvalid, s_axi_rready} <= {2{!we}};
		while (!done) begin
			@(negedge mclk);
			hs = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_arvalid & s_axi_arready};
			done = s_axi_bvalid & s_axi_bready | s_axi_rvalid & s_axi_rready;
			q = s_axi_rdata;
			r = we ? s_axi_bresp : s_axi_rresp;
			@(posedge mclk);
			if (hs[2]) s_axi_awvalid <= 1'b0;
			if (hs[1]) s_axi_wvalid <= 1'b0;
			if (hs[0]) s_axi_arvalid <= 1'b0;
		end
		{s_axi_bready, s_axi_rready} <= 2'b00;
	endtask : bus
	// clear the load counters, then let w cycles accumulate
	task automatic window(int w);
		ld_clr <= 1'b1;
		@(posedge mclk);
		ld_clr <= 1'b0;
		repeat (w) @(posedge mclk);
		@(negedge mclk);
	endtask : window
	always #5 mclk = ~mclk;
	always @(negedge mclk) if (restart_pulse === 1'b1) nrst++;
	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 6000) begin
			miscompares++;
			stop_test();
		end
	end
	initial begin
		{mclk, sys_rst} = 2'b01;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ld_clr} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, tune_event} = '0;
		s_axi_wstrb = 4'hF;
		v = $urandom(73);
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		bus(1'b0, 8'h04, 0);
		`CHK("period_reset", 32'h2, q)
		foreach (codes[i]) begin
			per = ticks(codes[i]);
			mv = i == 0 ? 0 : i == 1 ? 1000 : $urandom_range(999, 1);
			bus(1'b1, 8'h04, codes[i]);
			bus(1'b1, 8'h08, codes[i]);
			bus(1'b1, 8'h0C, mv);
			bus(1'b1, 8'h10, 1000 - mv);
			bus(1'b1, 8'h00, 32'h9);
			`CHK("write_ok", 2'b00, r)
			repeat (per * TCK + 4) @(posedge mclk);
			window(2 * per * TCK);
			`CHK("heat_on", 2 * (per * mv / 1000) * TCK, heat_on)
			`CHK("cool_on", 2 * (per * (1000 - mv) / 1000) * TCK, cool_on)
			bus(1'b0, 8'h2C, 0);
			`CHK("on_ticks", per * mv / 1000, q)
		end
		bus(1'b1, 8'h00, 32'h0);
		repeat (4) @(posedge mclk);
		window(40);
		`CHK("pid_off", 0, heat_on + cool_on)
		v = $urandom_range(255, 1);
		bus(1'b0, 8'h18, 0);
		q_old = q;
		bus(1'b1, 8'h14, v);
		bus(1'b1, 8'h1C, v);
		bus(1'b0, 8'h1C, 0);
		`CHK("pid_now", v, q)
		bus(1'b0, 8'h18, 0);
		`CHK("adapt_held", q_old, q)
		per = nrst + 1;
		bus(1'b1, 8'h00, 32'h3);
		repeat (3) @(posedge mclk);
		`CHK("restarts", per, nrst)
		bus(1'b0, 8'h18, 0);
		`CHK("adapt_live", v, q)
		bus(1'b1, 8'h28, 32'h1);
		for (int b = 0; b < 4; b++) begin
			@(posedge mclk);
			tune_event <= 4'h1 << b;
			@(posedge mclk);
			tune_event <= 4'h0;
			repeat (2) @(posedge mclk);
			@(negedge mclk);
			`CHK("irq_set", 1'b1, irq)
			bus(1'b1, 8'h00, 32'h8);
			bus(1'b0, 8'h20, 0);
			`CHK("flag_kept", 1'b1, q[0])
			bus(1'b1, 8'h00, 32'h4);
			bus(1'b0, 8'h20, 0);
			`CHK("flag_saved", 1'b0, q[0])
			bus(1'b1, 8'h24, 32'h3);
			repeat (2) @(posedge mclk);
			@(negedge mclk);
			`CHK("irq_clear", 1'b0, irq)
		end
		bus(1'b0, 8'h40, 0);
		`CHK("bad_read", {2'b10, 32'h0}, {r, q})
		bus(1'b1, 8'h40, 32'h1);
		`CHK("bad_write", 2'b10, r)
		stop_test();
	end
endmodule : test_time_proportional_output
`default_nettype wire

// *** dv/tpo_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
// pin-level watch of the register bus and the restart pulse
module tpo_checker (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic restart_pulse,
	input wire logic heat_out,
	input wire logic irq
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	// acceptance steps of a transfer
	sequence aw_taken;
		s_axi_awvalid && s_axi_awready;
	endsequence
	sequence ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	write_answer_a: assert property (aw_taken |-> ##[1:3] s_axi_bvalid)
		else $error("late write response");
	aw_block_a: assert property (aw_taken |=> !s_axi_awready)
		else $error("address taken twice");
	read_answer_a: assert property (ar_taken |=> s_axi_rvalid)
		else $error("late read data");
	ar_block_a: assert property (ar_taken |=> !s_axi_arready)
		else $error("read taken twice");
	write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
	restart_single_a: assert property ($rose(restart_pulse) |=> !restart_pulse)
		else $error("restart pulse too long");
	reset_quiet_a: assert property ($fell(sys_rst) |-> !heat_out && !irq && !restart_pulse)
		else $error("outputs busy after reset");
endmodule : tpo_checker
bind time_proportional_output tpo_checker chk (.mclk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.restart_pulse, .heat_out, .irq);
`default_nettype wire

// *** src/time_proportional_output.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tpo_defs.svh"
module time_proportional_output
	import tpo_pkg::*;
#(
	parameter bit SSR_VARIANT = 1'b1,
	parameter bit HEAT_COOL = 1'b1,
	parameter int TICK_CYCLES = `TICK_CYC
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] tune_event,
	output logic heat_out,
	output logic cool_out,
	output logic restart_pulse,
	output logic irq
);
	// refuse a timebase that the 24-bit tick counter cannot count
	if (TICK_CYCLES < 1 || TICK_CYCLES > 16777215) begin : g_tick_range
		$error("TICK_CYCLES out of range");
	end

	// tuning events come from other logic on mclk; no sync needed
	tune_ev_s ev;
	assign ev = tune_event;

	// period code to tick count (ticks of 0.1 s)
	// invalid codes fall back to the 2 s default
	function automatic logic [9:0] period_ticks(input logic [7:0] code);
		logic signed [7:0] c;
		c = code;
		if (c == -8'sd2) period_ticks = 10'd1;
		else if (c == -8'sd1) period_ticks = 10'd2;
		else if (c == 8'sd0) period_ticks = 10'd5;
		else if (c >= 8'sd1 && c <= 8'sd99) period_ticks = 10'(c) * 10'd10;
		else period_ticks = 10'd20;
	endfunction : period_ticks

	// on ticks = period * mv(0.1%) / 1000, mv saturated at full scale
	function automatic logic [9:0] on_ticks(input logic [9:0] per, input logic [9:0] mv);
		logic [19:0] p;
		logic [9:0] m;
		m = (mv > `MV_FULL) ? `MV_FULL : mv;
		p = per * m;
		on_ticks = 10'(p / 20'd1000);
	endfunction : on_ticks

	// software-visible registers; only the bits each field needs are kept
	logic [31:0] ctrl, heat_code, cool_code, heat_mv, cool_mv;
	logic [31:0] adapt_cfg, adapt_act, pid_val, irq_stat, irq_mask;
	logic [7:0] heat_act, cool_act;
	logic tuned_flag; // retained: only sys_rst (power-on) resets it
	logic restart_pend;

	// write channel
	logic aw_hold, w_hold;
	logic [7:0] aw_q;
	logic [31:0] w_q;
	logic [3:0] ws_q;
	// a write lands once address and data are both held and no answer waits
	wire do_wr = aw_hold && w_hold && !s_axi_bvalid;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire [31:0] wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
	wire wr_ctrl = do_wr && aw_q == `OFS_CTRL;
	wire wr_irqs = do_wr && aw_q == `OFS_IRQ_STAT;
	wire [31:0] wv = w_q & wmask;
	// every mapped offset answers OKAY; read-only ones ignore the data
	wire wr_ok = (aw_q == `OFS_CTRL) || (aw_q == `OFS_HEAT_PER) || (aw_q == `OFS_COOL_PER)
		|| (aw_q == `OFS_HEAT_MV) || (aw_q == `OFS_COOL_MV) || (aw_q == `OFS_ADAPT_CFG)
		|| (aw_q == `OFS_PID_VAL) || (aw_q == `OFS_IRQ_STAT) || (aw_q == `OFS_IRQ_MASK)
		|| (aw_q == `OFS_STATUS) || (aw_q == `OFS_ADAPT_ACT) || (aw_q == `OFS_PID_ACT);
	// control strobes: transfer, save and restart act only in the write cycle
	wire save_cmd = wr_ctrl && wv[`CTRL_SAVE];
	wire xfer_done = wr_ctrl && wv[`CTRL_TRANSFER];
	wire restart_now = wr_ctrl && wv[`CTRL_RESTART];
	// any of the four tuning sources marks the parameters updated
	wire tune_any = ev.auto_tuning || ev.filter_adj || ev.water_cool_adj || ev.adaptive;
	wire pid_mode = ctrl[`CTRL_PID];

	// adaptive-restart settings written since last restart
	wire restart_needed = restart_pend || (do_wr && aw_q == `OFS_ADAPT_CFG)
		|| (do_wr && (aw_q == `OFS_HEAT_PER || aw_q == `OFS_COOL_PER));
	wire fire_restart = (xfer_done && restart_needed) || restart_now;

	// byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [31:0] m);
		merge = (o & ~m) | (n & m);
	endfunction : merge

	// axi write handshake
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_q <= 8'h00;
			w_q <= 32'h0;
			ws_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end else begin
			if (aw_take) begin
				aw_hold <= 1'b1;
				s_axi_awready <= 1'b0;
				aw_q <= s_axi_awaddr;
			end
			if (w_take) begin
				w_hold <= 1'b1;
				s_axi_wready <= 1'b0;
				w_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			// the answer follows both halves; both readies reopen at that edge
			if (do_wr) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register storage; pid values apply at once, adaptive/period at restart
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl <= 32'h0;
			heat_code <= {24'h0, `PERIOD_RESET};
			cool_code <= {24'h0, `PERIOD_RESET};
			heat_mv <= 32'h0;
			cool_mv <= 32'h0;
			adapt_cfg <= 32'h0;
			pid_val <= 32'h0;
			irq_mask <= 32'h0;
		end else if (do_wr) begin
			// ctrl keeps only the mode bit; the other bits are strobes
			unique case (aw_q)
				`OFS_CTRL: ctrl <= merge(ctrl, w_q, wmask) & 32'h1;
				`OFS_HEAT_PER: heat_code <= merge(heat_code, w_q, wmask) & 32'hFF;
				`OFS_COOL_PER: cool_code <= merge(cool_code, w_q, wmask) & 32'hFF;
				`OFS_HEAT_MV: heat_mv <= merge(heat_mv, w_q, wmask) & 32'h3FF;
				`OFS_COOL_MV: cool_mv <= merge(cool_mv, w_q, wmask) & 32'h3FF;
				`OFS_ADAPT_CFG: adapt_cfg <= merge(adapt_cfg, w_q, wmask);
				`OFS_PID_VAL: pid_val <= merge(pid_val, w_q, wmask);
				`OFS_IRQ_MASK: irq_mask <= merge(irq_mask, w_q, wmask) & 32'h3;
				default: ;
			endcase
		end
	end

	// restart latching, tuning flag and interrupts
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			heat_act <= `PERIOD_RESET;
			cool_act <= `PERIOD_RESET;
			adapt_act <= 32'h0;
			restart_pend <= 1'b0;
			restart_pulse <= 1'b0;
			tuned_flag <= 1'b0;
			irq_stat <= 32'h0;
			irq <= 1'b0;
		end else begin
			restart_pulse <= fire_restart;
			restart_pend <= fire_restart ? 1'b0 : (restart_needed && !restart_now);
			if (fire_restart) begin
				heat_act <= heat_code[7:0];
				cool_act <= cool_code[7:0];
				adapt_act <= adapt_cfg;
			end
			// set wins over save clear; not cleared by restart
			if (tune_any) tuned_flag <= 1'b1;
			else if (save_cmd) tuned_flag <= 1'b0;
			// write-one-to-clear status: a clear meeting a new event leaves it set
			irq_stat <= {30'h0, (irq_stat[1] & ~(wr_irqs & wv[1])) | fire_restart,
				(irq_stat[0] & ~(wr_irqs & wv[0])) | tune_any};
			// level interrupt, one cycle behind the status
			irq <= |(irq_stat[1:0] & irq_mask[1:0]);
		end
	end

	// period generators: heating always, cooling only on heat/cool type
	// timebase: one tick per 0.1 s of control time
	logic [23:0] tick_cnt;
	wire tick = tick_cnt == 24'(TICK_CYCLES - 1);
	logic [9:0] h_pos, h_on, c_pos, c_on;
	wire [9:0] h_per = period_ticks(heat_act);
	wire [9:0] c_per = period_ticks(cool_act);
	// a restart begins the first period with the codes that it latches
	wire [9:0] h_per_new = fire_restart ? period_ticks(heat_code[7:0]) : h_per;
	wire [9:0] c_per_new = fire_restart ? period_ticks(cool_code[7:0]) : c_per;
	// a period ends on its last tick
	wire h_end = tick && (h_pos >= h_per - 10'd1);
	wire c_end = tick && (c_pos >= c_per - 10'd1);
	wire run = pid_mode && SSR_VARIANT;

	// outside PID mode or at restart the periods start over with the output off
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tick_cnt <= 24'h0;
			h_pos <= 10'h0;
			c_pos <= 10'h0;
			h_on <= 10'h0;
			c_on <= 10'h0;
			heat_out <= 1'b0;
			cool_out <= 1'b0;
		end else if (!run || fire_restart) begin
			tick_cnt <= 24'h0;
			h_pos <= 10'h0;
			c_pos <= 10'h0;
			h_on <= on_ticks(h_per_new, heat_mv[9:0]);
			c_on <= on_ticks(c_per_new, cool_mv[9:0]);
			heat_out <= 1'b0;
			cool_out <= 1'b0;
		end else begin
			tick_cnt <= tick ? 24'h0 : tick_cnt + 24'h1;
			if (h_end) begin
				h_pos <= 10'h0;
				h_on <= on_ticks(h_per, heat_mv[9:0]);
			end else if (tick) begin
				h_pos <= h_pos + 10'h1;
			end
			if (c_end) begin
				c_pos <= 10'h0;
				c_on <= on_ticks(c_per, cool_mv[9:0]);
			end else if (tick) begin
				c_pos <= c_pos + 10'h1;
			end
			// ON phase first: drive high while the tick position is below the ON count
			heat_out <= h_pos < h_on;
			cool_out <= HEAT_COOL && (c_pos < c_on);
		end
	end

	// read channel
	// status bits: restart pending, both drives and the tuning flag
	wire [31:0] status = {28'h0, restart_pend, cool_out, heat_out, tuned_flag};
	logic [31:0] rsel;
	logic rok;
	always_comb begin
		rok = 1'b1;
		unique case (s_axi_araddr)
			`OFS_CTRL: rsel = ctrl;
			`OFS_HEAT_PER: rsel = heat_code;
			`OFS_COOL_PER: rsel = HEAT_COOL ? cool_code : 32'h0;
			`OFS_HEAT_MV: rsel = heat_mv;
			`OFS_COOL_MV: rsel = cool_mv;
			`OFS_ADAPT_CFG: rsel = adapt_cfg;
			`OFS_ADAPT_ACT: rsel = adapt_act;
			`OFS_PID_VAL: rsel = pid_val;
			`OFS_STATUS: rsel = status;
			`OFS_IRQ_STAT: rsel = irq_stat;
			`OFS_IRQ_MASK: rsel = irq_mask;
			`OFS_PID_ACT: rsel = {16'h0, 6'h0, h_on};
			default: begin
				rsel = 32'h0;
				rok = 1'b0;
			end
		endcase
	end

	// read answer registered one cycle after the address is taken
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_arready <= 1'b0;
			s_axi_rdata <= rsel;
			s_axi_rresp <= rok ? 2'b00 : 2'b10;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule : time_proportional_output
`default_nettype wire

// *** src/tpo_defs.svh ***
// What this block does
// - period code -2,-1,0 give 0.1,0.2,0.5 s; 1..99 give seconds; default 2, taken at restart
// - one whole control period stands for a manipulated variable of 100 percent
// - ON time is period times percent over 100, OFF for the rest
// - time-proportional output runs only under PID control, otherwise output held off
// - selectable-period output exists only on the SSR voltage-output variant
// - cooling period and cooling output exist only on heating/cooling type
// - adaptive-control settings are latched into use only at restart
// - PID and response coefficient values take effect immediately on write
// - a transfer holding restart-applied settings triggers one restart when complete
// - own automatic tuning that changes a parameter sets the tuning-updated bit
// - auto-tuning, filter adjust, water-cooling adjust and adaptive control raise it
// - the tuning-updated bit is kept in retained storage across restarts
// - a save-unit-parameters command clears the tuning-updated bit
`ifndef TPO_DEFS_SVH
`define TPO_DEFS_SVH
`define OFS_CTRL 8'h00
`define OFS_HEAT_PER 8'h04
`define OFS_COOL_PER 8'h08
`define OFS_HEAT_MV 8'h0C
`define OFS_COOL_MV 8'h10
`define OFS_ADAPT_CFG 8'h14
`define OFS_ADAPT_ACT 8'h18
`define OFS_PID_VAL 8'h1C
`define OFS_STATUS 8'h20
`define OFS_IRQ_STAT 8'h24
`define OFS_IRQ_MASK 8'h28
`define OFS_PID_ACT 8'h2C
`define PERIOD_RESET 8'h02
`define TICK_NS 100000000
`define CLK_NS 10
`define TICK_CYC (`TICK_NS / `CLK_NS)
`define MV_FULL 10'd1000
`define CTRL_PID 0
`define CTRL_TRANSFER 1
`define CTRL_SAVE 2
`define CTRL_RESTART 3
`endif

// *** src/tpo_pkg.sv ***
package tpo_pkg;
	typedef struct packed {
		logic pid_mode;
		logic transfer_done;
		logic save_cmd;
		logic restart_cmd;
	} ctrl_s;
	typedef struct packed {
		logic auto_tuning;
		logic filter_adj;
		logic water_cool_adj;
		logic adaptive;
	} tune_ev_s;
endpackage : tpo_pkg
